//--- common/pbsc_map.vh
// widths, depths and reset values of the pipelined burst sram core
`ifndef PBSC_MAP_VH
`define PBSC_MAP_VH

`define PBSC_ADDR_W      19
`define PBSC_DEPTH       524288
`define PBSC_LANES       4
`define PBSC_BYTE_W      8
`define PBSC_LANE_W      9
`define PBSC_DATA_W      32
`define PBSC_WORD_W      36
`define PBSC_BURST_W     2

`define PBSC_ADDR_RST    19'h00000
`define PBSC_WORD_RST    36'h000000000
`define PBSC_CNT_RST     2'h0
`define PBSC_CNT_STEP    2'h1
`define PBSC_LANES_ALL   4'hF
`define PBSC_LANES_NONE  4'h0

`endif

//--- rtl/pbsc_core.v
// pipelined double-cycle-deselect burst sram core, 512K words of four 9-bit lanes
`timescale 1ns/100ps
`include "pbsc_map.vh"

module pbsc_core (
    input  wire                        ref_clk_in,
    input  wire                        nrst_in,
    input  wire [`PBSC_ADDR_W-1:0]     address_in,
    input  wire [`PBSC_DATA_W-1:0]     data_in,
    input  wire [`PBSC_LANES-1:0]      lane_parity_bit_in,
    input  wire                        processor_address_strobe_n_in,
    input  wire                        controller_address_strobe_n_in,
    input  wire                        burst_advance_n_in,
    input  wire                        byte_write_gate_n_in,
    input  wire                        lane0_write_select_n_in,
    input  wire                        lane1_write_select_n_in,
    input  wire                        lane2_write_select_n_in,
    input  wire                        lane3_write_select_n_in,
    input  wire                        global_write_n_in,
    input  wire                        chip_select_first_n_in,
    input  wire                        chip_select_second_in,
    input  wire                        chip_select_third_n_in,
    input  wire                        sleep_request_in,
    input  wire                        output_enable_n_in,
    input  wire                        burst_order_linear_in,
    input  wire                        read_ready_in,
    output wire [`PBSC_DATA_W-1:0]     data_out,
    output wire [`PBSC_LANES-1:0]      lane_parity_bit_out,
    output wire                        data_oe_n_out,
    output reg                         low_power_out,
    output reg  [`PBSC_WORD_W-1:0]     read_word_out,
    output reg                         read_valid_out,
    output reg                         read_buffer_full_out
);

    // =====================================================================
    // storage and pipeline registers
    // =====================================================================
    reg  [`PBSC_WORD_W-1:0]   mem [0:`PBSC_DEPTH-1];

    reg  [`PBSC_ADDR_W-1:0]   base_addr;
    reg  [`PBSC_BURST_W-1:0]  burst_cnt;
    reg                       selected;

    reg  [`PBSC_ADDR_W-1:0]   a_addr;
    reg                       a_rd;
    reg  [`PBSC_LANES-1:0]    a_lanes;
    reg  [`PBSC_WORD_W-1:0]   a_data;

    reg                       b_rd;
    reg  [`PBSC_WORD_W-1:0]   b_word;

    reg                       drive;
    reg  [`PBSC_WORD_W-1:0]   dq_word;

    reg  [`PBSC_WORD_W-1:0]   spare_word;

    // =====================================================================
    // lane packing
    // =====================================================================
    wire [`PBSC_WORD_W-1:0]   wr_word;
    genvar                    gi;

    generate
        for (gi = 0; gi < `PBSC_LANES; gi = gi + 1) begin : lane_g
            // each lane is its byte with its parity bit on top
            assign wr_word[gi*`PBSC_LANE_W +: `PBSC_LANE_W] =
                {lane_parity_bit_in[gi], data_in[gi*`PBSC_BYTE_W +: `PBSC_BYTE_W]};
            assign data_out[gi*`PBSC_BYTE_W +: `PBSC_BYTE_W] =
                dq_word[gi*`PBSC_LANE_W +: `PBSC_BYTE_W];
            assign lane_parity_bit_out[gi] = dq_word[gi*`PBSC_LANE_W + `PBSC_BYTE_W];
        end
    endgenerate

    // =====================================================================
    // access decode
    // =====================================================================
    wire                      enables_ok;
    wire                      start_proc;
    wire                      start_ctrl;
    wire                      start;
    wire [`PBSC_LANES-1:0]    lane_sel;
    reg  [`PBSC_LANES-1:0]    req_lanes;

    assign enables_ok = ~chip_select_first_n_in & chip_select_second_in & ~chip_select_third_n_in;
    // processor strobe is ignored while the first chip select is high
    assign start_proc = ~processor_address_strobe_n_in & ~chip_select_first_n_in;
    assign start_ctrl = ~controller_address_strobe_n_in;
    assign start      = start_proc | start_ctrl;

    assign lane_sel = ~{lane3_write_select_n_in, lane2_write_select_n_in,
                        lane1_write_select_n_in, lane0_write_select_n_in};

    always @* begin
        if (!global_write_n_in) begin
            req_lanes = `PBSC_LANES_ALL;
        end else if (!byte_write_gate_n_in) begin
            req_lanes = lane_sel;
        end else begin
            req_lanes = `PBSC_LANES_NONE;
        end
    end

    // =====================================================================
    // burst address generation
    // =====================================================================
    reg  [`PBSC_ADDR_W-1:0]   next_base_addr;
    reg  [`PBSC_BURST_W-1:0]  next_burst_cnt;
    reg                       next_selected;
    reg  [`PBSC_BURST_W-1:0]  low_bits;
    wire [`PBSC_ADDR_W-1:0]   eff_addr;

    always @* begin
        next_base_addr = base_addr;
        next_burst_cnt = burst_cnt;
        next_selected  = selected;
        if (sleep_request_in) begin
            next_selected = 1'b0;
        end else if (start) begin
            next_base_addr = address_in;
            next_burst_cnt = `PBSC_CNT_RST;
            next_selected  = enables_ok;
        end else if (selected && !burst_advance_n_in) begin
            next_burst_cnt = burst_cnt + `PBSC_CNT_STEP;
        end
    end

    always @* begin
        if (burst_order_linear_in) begin
            low_bits = next_base_addr[`PBSC_BURST_W-1:0] + next_burst_cnt;
        end else begin
            low_bits = next_base_addr[`PBSC_BURST_W-1:0] ^ next_burst_cnt;
        end
    end

    // only the two low bits move, so the burst wraps in its block
    assign eff_addr = {next_base_addr[`PBSC_ADDR_W-1:`PBSC_BURST_W], low_bits};

    // a write never rides on a processor-strobe start cycle
    wire                      is_write;
    assign is_write = (req_lanes != `PBSC_LANES_NONE) & ~start_proc;

    // a selected beat is either a read or a write, never both
    wire                      rd_access;
    wire                      wr_access;
    assign rd_access = next_selected & ~is_write;
    assign wr_access = next_selected & is_write;

    // =====================================================================
    // input register stage
    // =====================================================================
    always @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            base_addr <= `PBSC_ADDR_RST;
            burst_cnt <= `PBSC_CNT_RST;
            selected  <= 1'b0;
            a_addr    <= `PBSC_ADDR_RST;
            a_rd      <= 1'b0;
            a_lanes   <= `PBSC_LANES_NONE;
            a_data    <= `PBSC_WORD_RST;
        end else begin
            base_addr <= next_base_addr;
            burst_cnt <= next_burst_cnt;
            selected  <= next_selected;
            a_addr    <= eff_addr;
            a_rd      <= rd_access;
            a_lanes   <= wr_access ? req_lanes : `PBSC_LANES_NONE;
            a_data    <= wr_word;
        end
    end

    // =====================================================================
    // array: self-timed write commit and read
    // =====================================================================
    integer                   li;

    always @(posedge ref_clk_in) begin
        for (li = 0; li < `PBSC_LANES; li = li + 1) begin
            if (a_lanes[li]) begin
                mem[a_addr][li*`PBSC_LANE_W +: `PBSC_LANE_W] <= a_data[li*`PBSC_LANE_W +: `PBSC_LANE_W];
            end
        end
    end

    // a write commits one edge before the next access reads the array
    always @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            b_rd   <= 1'b0;
            b_word <= `PBSC_WORD_RST;
        end else begin
            b_rd <= a_rd;
            if (a_rd) begin
                b_word <= mem[a_addr];
            end
        end
    end

    // =====================================================================
    // output stage
    // =====================================================================
    always @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            drive         <= 1'b0;
            dq_word       <= `PBSC_WORD_RST;
        end else begin
            // read valid travels two stages, so deselect releases late
            drive         <= b_rd;
            if (b_rd) begin
                dq_word <= b_word;
            end
        end
    end

    // =====================================================================
    // power state
    // =====================================================================
    // deselect counts as soon as it is decided, not a beat later
    always @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            low_power_out <= 1'b0;
        end else begin
            low_power_out <= sleep_request_in | ~next_selected;
        end
    end

    // output enable gates the drive without a clock edge
    assign data_oe_n_out = ~drive | output_enable_n_in;

    // =====================================================================
    // two-entry read buffer
    // =====================================================================
    wire                      push;
    wire                      pop;

    assign push = b_rd;
    assign pop  = read_valid_out & read_ready_in;

    reg  [`PBSC_WORD_W-1:0]   next_read_word;
    reg                       next_read_valid;
    reg  [`PBSC_WORD_W-1:0]   next_spare_word;
    reg                       next_buffer_full;

    always @* begin
        next_read_word   = read_word_out;
        next_read_valid  = read_valid_out;
        next_spare_word  = spare_word;
        next_buffer_full = read_buffer_full_out;
        if (pop || !read_valid_out) begin
            if (read_buffer_full_out) begin
                next_read_word  = spare_word;
                next_read_valid = 1'b1;
                if (push) begin
                    next_spare_word = b_word;
                end else begin
                    next_buffer_full = 1'b0;
                end
            end else begin
                next_read_word  = b_word;
                next_read_valid = push;
            end
        end else if (push && !read_buffer_full_out) begin
            // a beat that finds both entries taken is dropped, older words kept
            next_spare_word  = b_word;
            next_buffer_full = 1'b1;
        end
    end

    always @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            read_word_out        <= `PBSC_WORD_RST;
            read_valid_out       <= 1'b0;
            spare_word           <= `PBSC_WORD_RST;
            read_buffer_full_out <= 1'b0;
        end else begin
            read_word_out        <= next_read_word;
            read_valid_out       <= next_read_valid;
            spare_word           <= next_spare_word;
            read_buffer_full_out <= next_buffer_full;
        end
    end

endmodule

//--- testbench/pbsc_bus_model.sv
// bus master model driving the synchronous controls of the sram core
`timescale 1ns/100ps
// ========
// bus master
module pbsc_bus_model (
    input  wire        ref_clk_in,
    output reg  [18:0] address_out,
    output reg  [31:0] wdata_out,
    output reg  [3:0]  parity_out,
    output reg  [5:0]  write_ctl_out,
    output reg  [2:0]  select_out,
    output reg         proc_strobe_n_out,
    output reg         ctrl_strobe_n_out,
    output reg         advance_n_out
);
    // one cycle: 0 deselect, 1 write, 2 read start, 3 advance
    task cyc(input [1:0] k, input [18:0] a, input [35:0] d, input [5:0] w);
        begin
            proc_strobe_n_out = (k != 2'h2);
            ctrl_strobe_n_out = !(k < 2'h2);
            advance_n_out = (k != 2'h3);
            select_out = (k == 2'h0) ? 3'h5 : 3'h2;
            write_ctl_out = (k == 2'h1) ? w : 6'h3F;
            address_out = a;
            wdata_out = {d[34:27], d[25:18], d[16:9], d[7:0]};
            parity_out = {d[35], d[26], d[17], d[8]};
            @(posedge ref_clk_in);
            #1;
        end
    endtask
    initial cyc(2'h0, 19'h00000, 36'h000000000, 6'h3F);
endmodule

//--- testbench/pbsc_core_checker.sv
// concurrent checks on the ports of the pipelined burst sram core
`timescale 1ns/100ps
// ========
// checker
module pbsc_checker (
    input wire ref_clk_in,
    input wire nrst_in,
    input wire processor_address_strobe_n_in,
    input wire chip_select_first_n_in,
    input wire chip_select_second_in,
    input wire chip_select_third_n_in,
    input wire sleep_request_in,
    input wire output_enable_n_in,
    input wire read_ready_in,
    input wire data_oe_n_out,
    input wire low_power_out,
    input wire read_valid_out,
    input wire read_buffer_full_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    // selected read start through the processor strobe
    wire rd = !processor_address_strobe_n_in && !chip_select_first_n_in && chip_select_second_in
              && !chip_select_third_n_in && !sleep_request_in;
    property p_oe; output_enable_n_in |-> data_oe_n_out; endproperty
    a_oe: assert property (p_oe) else $error("drive while output enable high");
    property p_slp; sleep_request_in |=> low_power_out; endproperty
    a_slp: assert property (p_slp) else $error("no low power in sleep");
    property p_dcd; sleep_request_in [*3] |=> data_oe_n_out; endproperty
    a_dcd: assert property (p_dcd) else $error("outputs still driven");
    property p_lat; rd |-> ##3 read_valid_out; endproperty
    a_lat: assert property (p_lat) else $error("read word late");
    property p_drv; rd ##2 1 |=> output_enable_n_in || !data_oe_n_out; endproperty
    a_drv: assert property (p_drv) else $error("read data not driven");
    property p_full; read_buffer_full_out |-> read_valid_out; endproperty
    a_full: assert property (p_full) else $error("full without valid");
    property p_hold; read_valid_out && !read_ready_in |=> read_valid_out; endproperty
    a_hold: assert property (p_hold) else $error("word dropped in stall");
    property p_keep; read_buffer_full_out && !read_ready_in |=> read_buffer_full_out; endproperty
    a_keep: assert property (p_keep) else $error("full lost in stall");
    property p_one; !read_valid_out |=> !read_buffer_full_out; endproperty
    a_one: assert property (p_one) else $error("two words in one cycle");
endmodule
bind pbsc_core pbsc_checker u_chk (.*);

//--- testbench/tb_pbsc_core.sv
// self-checking bench for the pipelined burst sram core
`timescale 1ns/100ps
// ========
// bench
module tb_pbsc_core;
    reg ref_clk_in = 1'b0;
    reg nrst_in = 1'b0;
    reg sleep_request_in = 1'b0;
    reg output_enable_n_in = 1'b0;
    reg burst_order_linear_in = 1'b0;
    reg read_ready_in = 1'b1;
    wire [18:0] address_in;
    wire [31:0] data_in, data_out;
    wire [3:0] lane_parity_bit_in, lane_parity_bit_out;
    wire processor_address_strobe_n_in, controller_address_strobe_n_in, burst_advance_n_in;
    wire byte_write_gate_n_in, global_write_n_in, data_oe_n_out, low_power_out;
    wire lane0_write_select_n_in, lane1_write_select_n_in, lane2_write_select_n_in, lane3_write_select_n_in;
    wire chip_select_first_n_in, chip_select_second_in, chip_select_third_n_in;
    wire [35:0] read_word_out;
    wire read_valid_out, read_buffer_full_out;
    integer err_count = 0;
    integer cmp_count = 0;
    integer i, m;
    reg [9:0] r;
    reg [35:0] wd;
    reg [35:0] expq [0:3];
    // rows: write controls {global, gate, lanes 3..0}, lanes expected written
    reg [9:0] rows [0:6] = '{10'h1FF, 10'h0FF, 10'h2E1, 10'h25A, 10'h20F, 10'h300, 10'h278};
    initial forever #5 ref_clk_in = ~ref_clk_in;
    pbsc_core u_dut (.*);
    pbsc_bus_model u_bus (
        .ref_clk_in        (ref_clk_in),
        .address_out       (address_in),
        .wdata_out         (data_in),
        .parity_out        (lane_parity_bit_in),
        .write_ctl_out     ({global_write_n_in, byte_write_gate_n_in, lane3_write_select_n_in,
                             lane2_write_select_n_in, lane1_write_select_n_in, lane0_write_select_n_in}),
        .select_out        ({chip_select_first_n_in, chip_select_second_in, chip_select_third_n_in}),
        .proc_strobe_n_out (processor_address_strobe_n_in),
        .ctrl_strobe_n_out (controller_address_strobe_n_in),
        .advance_n_out     (burst_advance_n_in)
    );
    task tally_and_finish;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, err_count);
            if (err_count == 0 && cmp_count > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task chk(input [35:0] seen, input [35:0] exp, input string what);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("mismatch %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // wait for a buffered word, compare it, let it be popped
    task getw(input [35:0] exp, input p);
        integer t;
        begin
            t = 0;
            while (read_valid_out !== 1'b1 && t < 8) begin
                @(posedge ref_clk_in);
                #1;
                t = t + 1;
            end
            if (t == 8) begin
                err_count = err_count + 1;
                tally_and_finish;
            end else begin
                chk(read_word_out, exp, "read_word");
                if (p) begin
                    chk({4'h0, data_out}, {4'h0, exp[34:27], exp[25:18], exp[16:9], exp[7:0]}, "data_out");
                    chk({32'h0, lane_parity_bit_out}, {32'h0, exp[35], exp[26], exp[17], exp[8]}, "lane_parity");
                    chk({35'h0, data_oe_n_out}, {35'h0, output_enable_n_in}, "data_oe_n");
                end
                @(posedge ref_clk_in);
                #1;
            end
        end
    endtask
    task wr(input [18:0] a, input [5:0] w);
        begin
            u_bus.cyc(2'h1, a, wd, w);
            u_bus.cyc(2'h0, a, wd, w);
        end
    endtask
    // read burst of n beats, collecting m words meanwhile
    task rdn(input [18:0] a, input integer n, input integer m);
        integer j, k;
        begin
            fork
                begin
                    u_bus.cyc(2'h2, a, wd, 6'h3F);
                    for (j = 1; j < n; j = j + 1)
                        u_bus.cyc(2'h3, a, wd, 6'h3F);
                    u_bus.cyc(2'h0, a, wd, 6'h3F);
                end
                for (k = 0; k < m; k = k + 1)
                    getw(expq[k], 1'b1);
            join
        end
    endtask
    initial begin
        repeat (8) @(posedge ref_clk_in);
        #1;
        nrst_in = 1'b1;
        for (i = 0; i < 7; i = i + 1) begin
            r = rows[i];
            wd = 36'h000000000;
            wr({i[16:0], 2'h0}, 6'h1F);
            wd = 36'hFFFFFFFFF;
            wr({i[16:0], 2'h0}, r[9:4]);
            expq[0] = {{9{r[3]}}, {9{r[2]}}, {9{r[1]}}, {9{r[0]}}};
            rdn({i[16:0], 2'h0}, 1, 1);
        end
        for (i = 0; i < 5; i = i + 1) begin
            wd = 36'hA5A5A5A50 + i;
            wr(19'h00100 + i[18:0], 6'h1F);
        end
        for (m = 0; m < 2; m = m + 1) begin
            burst_order_linear_in = m[0];
            for (i = 0; i < 4; i = i + 1)
                expq[i] = 36'hA5A5A5A50 + (m ? ((i + 1) % 4) : (i ^ 1));
            rdn(19'h00101, 4, 4);
        end
        wd = 36'h123456789;
        u_bus.cyc(2'h1, 19'h00200, wd, 6'h1F);
        expq[0] = wd;
        rdn(19'h00200, 1, 1);
        output_enable_n_in = 1'b1;
        rdn(19'h00200, 1, 1);
        output_enable_n_in = 1'b0;
        read_ready_in = 1'b0;
        rdn(19'h00101, 4, 0);
        repeat (3) @(posedge ref_clk_in);
        #1;
        chk({35'h0, read_buffer_full_out}, 36'h1, "buffer_full");
        read_ready_in = 1'b1;
        getw(36'hA5A5A5A51, 1'b0);
        getw(36'hA5A5A5A52, 1'b0);
        chk({35'h0, read_valid_out}, 36'h0, "read_valid");
        sleep_request_in = 1'b1;
        rdn(19'h00200, 1, 0);
        repeat (3) @(posedge ref_clk_in);
        #1;
        chk({35'h0, low_power_out}, 36'h1, "low_power");
        chk({35'h0, read_valid_out}, 36'h0, "read_valid");
        sleep_request_in = 1'b0;
        nrst_in = 1'b0;
        #1;
        chk({32'h0, data_oe_n_out, read_valid_out, read_buffer_full_out, low_power_out}, 36'h8, "reset_outputs");
        @(posedge ref_clk_in);
        #1;
        nrst_in = 1'b1;
        @(posedge ref_clk_in);
        #1;
        chk({35'h0, low_power_out}, 36'h1, "low_power_deselect");
        expq[0] = wd;
        rdn(19'h00200, 1, 1);
        tally_and_finish;
    end
endmodule
